// ===== hdl/srt_pkg.sv
// Constants, field layouts and states of the run-time command block.
// Assumes a single 25 MHz instrument clock shared by all users.
package srt_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 40_000;
  // One scan cycle, 22.35 us, in picoseconds
  localparam int unsigned SCAN_CYCLE_PS = 22_350_000;
  // Scan cycle is only approximate, so the count rounds down
  localparam logic [9:0] SCAN_CYCLE_CLKS =
    10'(SCAN_CYCLE_PS / CLK_PERIOD_PS);
  localparam int unsigned MS_PS = 1_000_000_000;
  localparam int unsigned MS_CLKS = MS_PS / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Packet header fixed values
  // ----------------------------------------------------------------
  localparam logic [2:0] HDR_VERSION = 3'h0;
  localparam logic HDR_TYPE = 1'b1;
  localparam logic HDR_SEC_FLAG = 1'b1;
  localparam logic [3:0] HDR_CATEGORY = 4'hc;
  localparam logic [1:0] HDR_SEQ_FLAGS = 2'h3;
  localparam logic [2:0] HDR_GROUND_SRC = 3'h0;
  localparam logic [15:0] HDR_LENGTH = 16'h0007;
  localparam logic [2:0] SEC_STD_VERSION = 3'h0;
  localparam logic SEC_CKSUM_FLAG = 1'b1;
  localparam logic [3:0] SEC_ACK = 4'h1;
  localparam logic [7:0] PKT_TYPE = 8'hc0;
  localparam logic [7:0] PKT_SUBTYPE = 8'h0c;
  localparam logic [7:0] PKT_PAD = 8'h00;

  // Byte positions within the 14-byte packet
  localparam logic [3:0] IX_ID = 4'h0, IX_CAT = 4'h1, IX_SEQ = 4'h2,
    IX_LEN_HI = 4'h4, IX_LEN_LO = 4'h5, IX_SEC = 4'h6,
    IX_TYPE = 4'h7, IX_SUB = 4'h8, IX_PAD = 4'h9,
    IX_DATA_HI = 4'ha, IX_DATA_LO = 4'hb, IX_CK_HI = 4'hc,
    IX_CK_LO = 4'hd;

  // ----------------------------------------------------------------
  // Run-time setting layout
  // ----------------------------------------------------------------
  localparam int unsigned LARGE_BIT = 15;
  localparam int unsigned SMALL_BIT = 14;
  localparam int unsigned COUNT_W = 14;
  localparam int unsigned SMALL_SHIFT = 4;
  localparam int unsigned LARGE_SHIFT = 8;
  localparam int unsigned CYC_W = 26;
  localparam logic [15:0] DEF_SETTING = 16'h7622;

  // ----------------------------------------------------------------
  // Statistics and failure check
  // ----------------------------------------------------------------
  localparam logic [6:0] CONT_LAST = 7'h64;
  // Minimum-gap marker of 10.0 s, held in milliseconds
  localparam logic [13:0] GAP_INIT_MS = 14'h2710;
  localparam logic [13:0] GAP_SAT_MS = 14'h3fff;

  typedef enum logic [1:0] {
    SRT_IDLE = 2'h0,
    SRT_SCAN = 2'h1,
    SRT_GAP = 2'h3,
    SRT_ENG = 2'h2
  } srt_state_t;

endpackage

// ===== hdl/srt_cmd_if.sv
// Carries a checked command from the packet checker to the core.
// Assumes both ends share one clock; pulses last one cycle.
`timescale 1ns/10ps
interface srt_cmd_if;
  logic accept;
  logic reject;
  logic [15:0] setting;
  modport src (output accept, output reject, output setting);
  modport dst (input accept, input reject, input setting);
endinterface

// ===== hdl/srt_pkt_check.sv
// Byte-serial checker for the run-time telecommand packet.
// Assumes bytes arrive on the instrument clock, first byte flagged.
`timescale 1ns/10ps
module srt_pkt_check #(
  parameter logic [6:0] APP_ID = 7'h2a // Arbitrary identifier value
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] tc_byte_in,
  input wire logic tc_valid_in,
  input wire logic tc_sop_in,
  srt_cmd_if.src cmd
);
  import srt_pkg::*;

  typedef struct packed {
    logic [3:0] idx;
    logic act;
    logic ok;
    logic mine;
    logic [15:0] ck;
    logic [7:0] hold;
    logic [15:0] data;
    logic acc;
    logic rej;
  } srt_chk_t;

  srt_chk_t r, n;

  // ----------------------------------------------------------------
  // Per-byte header check: {fields ok, is this command}
  // ----------------------------------------------------------------
  function automatic logic [1:0] srt_byte_chk(input logic [3:0] ix,
                                              input logic [7:0] b);
    logic ok;
    logic mine;
    ok = 1'b1;
    mine = 1'b1;
    if (ix == IX_ID) begin
      ok = b == {HDR_VERSION, HDR_TYPE, HDR_SEC_FLAG, APP_ID[6:4]};
    end else if (ix == IX_CAT) begin
      ok = b == {APP_ID[3:0], HDR_CATEGORY};
    end else if (ix == IX_SEQ) begin
      // Counter bits are free; only flags and ground source checked
      ok = b[7:3] == {HDR_SEQ_FLAGS, HDR_GROUND_SRC};
    end else if (ix == IX_LEN_HI) begin
      ok = b == HDR_LENGTH[15:8];
    end else if (ix == IX_LEN_LO) begin
      ok = b == HDR_LENGTH[7:0];
    end else if (ix == IX_SEC) begin
      ok = b == {SEC_STD_VERSION, SEC_CKSUM_FLAG, SEC_ACK};
    end else if (ix == IX_TYPE) begin
      mine = b == PKT_TYPE;
    end else if (ix == IX_SUB) begin
      mine = b == PKT_SUBTYPE;
    end else if (ix == IX_PAD) begin
      ok = b == PKT_PAD;
    end
    return {ok, mine};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] ix;
    logic okv;
    logic minev;
    logic [15:0] ckv;
    logic [1:0] chk;
    ix = tc_sop_in ? IX_ID : r.idx;
    okv = tc_sop_in ? 1'b1 : r.ok;
    minev = tc_sop_in ? 1'b1 : r.mine;
    ckv = tc_sop_in ? 16'h0000 : r.ck;
    chk = srt_byte_chk(ix, tc_byte_in);
    n = r;
    n.acc = 1'b0;
    n.rej = 1'b0;
    if (tc_valid_in && (tc_sop_in || r.act)) begin
      // A new start cuts short a packet still in flight
      if (tc_sop_in && r.act && r.mine) begin
        n.rej = 1'b1;
      end
      n.act = 1'b1;
      n.ok = okv & chk[1];
      n.mine = minev & chk[0];
      // Checksum is the XOR of the six leading 16-bit words
      n.ck = ix[0] ? ckv ^ {8'h00, tc_byte_in} : ckv ^ {tc_byte_in, 8'h00};
      if (ix >= IX_CK_HI) begin
        n.ck = ckv;
      end
      if (ix == IX_DATA_HI) begin
        n.data[15:8] = tc_byte_in;
      end
      if (ix == IX_DATA_LO) begin
        n.data[7:0] = tc_byte_in;
      end
      if (ix == IX_CK_HI) begin
        n.hold = tc_byte_in;
      end
      n.idx = ix + 4'h1;
      if (ix == IX_CK_LO) begin
        n.act = 1'b0;
        // Packets of another type are left alone, not refused
        if (minev & chk[0]) begin
          if (okv && ckv == {r.hold, tc_byte_in}) begin
            n.acc = 1'b1;
          end else begin
            n.rej = 1'b1;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign cmd.accept = r.acc;
  assign cmd.reject = r.rej;
  assign cmd.setting = r.data;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  accept_excl_a: assert property (!(r.acc && r.rej))
    else $error("accept and reject together");
  short_drop_a: assert property (
    tc_valid_in && tc_sop_in |=> !r.acc [*8])
    else $error("accept too soon after packet start");
endmodule

// ===== hdl/srt_run_time.sv
// Run-time command core: applies the scan setting, times scans,
// keeps scan-time and unloading-gap statistics, watches busy.
// Assumes packet bytes, restart, scan start, continuum interrupt
// and readout-done pulses come from logic on the same clock; the
// spectrometer busy line is an asynchronous pin.
`timescale 1ns/10ps
module srt_run_time #(
  parameter logic [6:0] APP_ID = 7'h2a, // Arbitrary identifier value
  parameter int unsigned MS_CLKS = srt_pkg::MS_CLKS
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] tc_byte_in,
  input wire logic tc_valid_in,
  input wire logic tc_sop_in,
  input wire logic sw_restart_in,
  input wire logic scan_start_in,
  input wire logic cont_irq_in,
  input wire logic readout_done_in,
  input wire logic spec_busy_in,
  output logic [15:0] timing_setting_out,
  output logic [srt_pkg::CYC_W-1:0] scan_cycles_out,
  output logic scan_run_out,
  output logic cmd_accept_out,
  output logic cmd_reject_out,
  output logic [srt_pkg::CYC_W-1:0] avg_scan_out,
  output logic [13:0] last_gap_ms_out,
  output logic [13:0] min_gap_ms_out,
  output logic eng_mode_out,
  output logic spectrometer_error_event_out
);
  import srt_pkg::*;

  typedef struct packed {
    srt_state_t st;
    logic bs1;
    logic bs2;
    logic bd;
    logic [15:0] setting;
    logic [CYC_W-1:0] cycles;
    logic [CYC_W-1:0] act;
    logic [CYC_W-1:0] left;
    logic [9:0] pre;
    logic [CYC_W-1:0] elapsed;
    logic [CYC_W-1:0] avg;
    logic [6:0] cont;
    logic [15:0] mspre;
    logic [13:0] gap;
    logic [13:0] last_gap;
    logic [13:0] min_gap;
    logic run;
    logic eng;
    logic err;
    logic acc;
    logic rej;
  } srt_core_t;

  srt_core_t r, n;
  srt_cmd_if cmd ();

  // ----------------------------------------------------------------
  // Packet checker
  // ----------------------------------------------------------------
  srt_pkt_check #(
    .APP_ID(APP_ID)
  ) u_check (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .tc_byte_in(tc_byte_in),
    .tc_valid_in(tc_valid_in),
    .tc_sop_in(tc_sop_in),
    .cmd(cmd)
  );

  // ----------------------------------------------------------------
  // Setting to scan cycle count
  // ----------------------------------------------------------------
  function automatic logic [CYC_W-1:0] srt_cycles(input logic [15:0] s);
    logic [CYC_W-1:0] c;
    c = CYC_W'(s[COUNT_W-1:0]);
    if (s[SMALL_BIT]) begin
      c = c << SMALL_SHIFT;
    end
    if (s[LARGE_BIT]) begin
      c = c << LARGE_SHIFT;
    end
    return c;
  endfunction

  localparam logic [CYC_W-1:0] DEF_CYCLES = srt_cycles(DEF_SETTING);
  localparam logic [15:0] MS_LAST = 16'(MS_CLKS - 1);

  wire logic busy = r.bs2;
  wire logic tick = r.pre == SCAN_CYCLE_CLKS - 10'h001;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [CYC_W:0] sum;
    sum = {1'b0, r.avg} + {1'b0, r.elapsed};
    n = r;
    n.err = 1'b0;
    n.acc = cmd.accept;
    n.rej = cmd.reject;
    // Busy is a pin: two stages before anything looks at it
    n.bs1 = spec_busy_in;
    n.bs2 = r.bs1;
    n.bd = busy;

    // Scan timer; the length was latched when the scan began. It runs
    // on past the 100th interrupt so the run flag cannot stick high.
    if (r.st == SRT_SCAN || r.run) begin
      n.pre = tick ? 10'h000 : r.pre + 10'h001;
      if (tick && r.left != '0) begin
        n.left = r.left - CYC_W'(1);
        n.run = r.left != CYC_W'(1);
      end
    end

    // Busy time and interrupt count only matter inside a scan
    if (r.st == SRT_SCAN) begin
      if (tick && busy) begin
        n.elapsed = r.elapsed + CYC_W'(1);
      end
      // End of busy closes the scan-time average
      if (r.bd && !busy) begin
        n.avg = r.avg == '0 ? r.elapsed : sum[CYC_W:1];
      end
      if (cont_irq_in) begin
        n.cont = r.cont + 7'h01;
        if (r.cont == CONT_LAST - 7'h01) begin
          if (busy) begin
            n.st = SRT_ENG;
            n.eng = 1'b1;
            n.err = 1'b1;
            n.run = 1'b0;
          end else begin
            n.st = SRT_GAP;
            n.gap = '0;
            n.mspre = '0;
          end
        end
      end
    end

    case (r.st)
      SRT_IDLE: begin
        if (scan_start_in) begin
          n.st = SRT_SCAN;
          n.act = r.cycles;
          n.left = r.cycles;
          n.run = r.cycles != '0;
          n.pre = '0;
          n.elapsed = '0;
          n.cont = '0;
        end
      end
      SRT_GAP: begin
        // Gap in milliseconds from the 100th interrupt to readout end
        n.mspre = r.mspre == MS_LAST ? 16'h0000 : r.mspre + 16'h0001;
        if (r.mspre == MS_LAST && r.gap != GAP_SAT_MS) begin
          n.gap = r.gap + 14'h0001;
        end
        if (readout_done_in) begin
          n.last_gap = r.gap;
          if (r.gap < r.min_gap) begin
            n.min_gap = r.gap;
          end
          n.st = SRT_IDLE;
        end
      end
      default: begin
      end
    endcase

    // A checked command takes effect at once on the timing setting
    if (cmd.accept) begin
      n.setting = cmd.setting;
      n.cycles = srt_cycles(cmd.setting);
      n.avg = '0;
      n.min_gap = GAP_INIT_MS;
    end

    // Restart wins over everything but the reject and error pulses, including a same-cycle command
    if (sw_restart_in) begin
      n.setting = DEF_SETTING;
      n.cycles = DEF_CYCLES;
      n.avg = '0;
      n.min_gap = GAP_INIT_MS;
      n.last_gap = GAP_INIT_MS;
      n.st = SRT_IDLE;
      n.eng = 1'b0;
      n.run = 1'b0;
      n.acc = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.st <= SRT_IDLE;
      r.setting <= DEF_SETTING;
      r.cycles <= DEF_CYCLES;
      r.min_gap <= GAP_INIT_MS;
      r.last_gap <= GAP_INIT_MS;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign timing_setting_out = r.setting;
  assign scan_cycles_out = r.cycles;
  assign scan_run_out = r.run;
  assign cmd_accept_out = r.acc;
  assign cmd_reject_out = r.rej;
  assign avg_scan_out = r.avg;
  assign last_gap_ms_out = r.last_gap;
  assign min_gap_ms_out = r.min_gap;
  assign eng_mode_out = r.eng;
  assign spectrometer_error_event_out = r.err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence take_cmd;
    cmd.accept && !sw_restart_in;
  endsequence

  sequence hundredth_busy;
    r.st == SRT_SCAN && cont_irq_in && r.cont == CONT_LAST - 7'h01
      && busy && !sw_restart_in;
  endsequence

  sequence scan_begin;
    r.st == SRT_IDLE && scan_start_in && !sw_restart_in;
  endsequence

  restart_default_a: assert property (
    sw_restart_in |=> timing_setting_out == DEF_SETTING
      && scan_cycles_out == 26'h0036220 && !eng_mode_out)
    else $error("restart did not load default setting");
  accept_load_a: assert property (
    take_cmd |=> timing_setting_out == $past(cmd.setting)
      && cmd_accept_out)
    else $error("accepted setting not applied");
  cycle_calc_a: assert property (
    scan_cycles_out == (CYC_W'(timing_setting_out[13:0])
      << (timing_setting_out[14] ? 4 : 0)
      << (timing_setting_out[15] ? 8 : 0)))
    else $error("cycle count does not match setting");
  stats_clear_a: assert property (
    take_cmd |=> avg_scan_out == '0 && min_gap_ms_out == 14'h2710)
    else $error("statistics not reset on command");
  setting_hold_a: assert property (
    !cmd.accept && !sw_restart_in |=> $stable(timing_setting_out))
    else $error("setting changed without cause");
  next_scan_a: assert property (
    scan_begin ##1 (r.st == SRT_SCAN) [*2] |-> $stable(r.act))
    else $error("active scan length changed mid-scan");
  scan_len_a: assert property (
    scan_begin |=> r.act == $past(scan_cycles_out)
      && scan_run_out == ($past(scan_cycles_out) != '0))
    else $error("scan did not start with latched length");
  fail_detect_a: assert property (
    hundredth_busy |=> spectrometer_error_event_out && eng_mode_out
      ##1 !spectrometer_error_event_out)
    else $error("busy at 100th interrupt not flagged");
  eng_hold_a: assert property (
    eng_mode_out && !sw_restart_in |=> eng_mode_out && !scan_run_out)
    else $error("engineering mode left without restart");
  gap_bound_a: assert property (min_gap_ms_out <= 14'h2710)
    else $error("minimum gap above marker value");
endmodule

// ===== bench/srt_spec_model.sv
// Behavioural spectrometer: busy line, continuum interrupts, readout.
// Assumes scan_start pulses arrive on the rising edge of clock_in.
`timescale 1ns/10ps
module srt_spec_model #(
  parameter int BUSY_CLKS = 1200,
  parameter int IRQ_AT = 1300,
  parameter int GAP_CLKS = 35
) (
  input wire logic clock_in,
  input wire logic scan_start_in,
  input wire logic stuck_in,
  output logic spec_busy_out,
  output logic cont_irq_out,
  output logic readout_done_out
);
  // ----------------------------------------------------------------
  // Scan timeline
  // ----------------------------------------------------------------
  initial begin
    spec_busy_out = 1'b0;
    cont_irq_out = 1'b0;
    readout_done_out = 1'b0;
  end

  // One scan per start; a stuck scan keeps busy high until released
  always begin
    @(posedge clock_in iff scan_start_in);
    @(negedge clock_in);
    spec_busy_out = 1'b1;
    for (int k = 1; k <= IRQ_AT + 199; k++) begin
      @(negedge clock_in);
      if (k == BUSY_CLKS && !stuck_in) begin
        spec_busy_out = 1'b0;
      end
      cont_irq_out = (k >= IRQ_AT) && ((k - IRQ_AT) % 2 == 0);
    end
    @(negedge clock_in);
    cont_irq_out = 1'b0;
    repeat (GAP_CLKS - 1) @(negedge clock_in);
    readout_done_out = 1'b1;
    @(negedge clock_in);
    readout_done_out = 1'b0;
    wait (!stuck_in);
    spec_busy_out = 1'b0;
  end
endmodule

// ===== bench/srt_run_time_tb.sv
// Self-checking bench for the run-time command core.
// Assumes the spectrometer model drives busy, interrupts and readout.
`timescale 1ns/10ps
module srt_run_time_tb;
  import srt_pkg::*;
  localparam logic [6:0] APP = 7'h2a; // Arbitrary identifier value
  logic clk, rst_n, tc_valid, tc_sop, sw_restart, scan_start, stuck;
  logic [7:0] tc_byte;
  logic busy, irq, done;
  logic [15:0] setting;
  logic [CYC_W-1:0] cycles, avg;
  logic run, acc, rej, eng, err;
  logic [13:0] last_gap, min_gap;
  logic [10:0] seq;
  int miscompares, comparisons;

  // ----------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------
  srt_run_time #(.APP_ID(APP), .MS_CLKS(10)) srt_run_time_i (
    .clock_in(clk), .reset_n_in(rst_n), .tc_byte_in(tc_byte),
    .tc_valid_in(tc_valid), .tc_sop_in(tc_sop),
    .sw_restart_in(sw_restart), .scan_start_in(scan_start),
    .cont_irq_in(irq), .readout_done_in(done), .spec_busy_in(busy),
    .timing_setting_out(setting), .scan_cycles_out(cycles),
    .scan_run_out(run), .cmd_accept_out(acc), .cmd_reject_out(rej),
    .avg_scan_out(avg), .last_gap_ms_out(last_gap),
    .min_gap_ms_out(min_gap), .eng_mode_out(eng),
    .spectrometer_error_event_out(err));

  srt_spec_model srt_spec_model_i (
    .clock_in(clk), .scan_start_in(scan_start), .stuck_in(stuck),
    .spec_busy_out(busy), .cont_irq_out(irq), .readout_done_out(done));

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Run should need about 5000 cycles; allow plenty of margin
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Used where sync delay and rounding make the figure loose
  task automatic check_range(input string what, input int lo,
                             input int hi, input logic [31:0] got);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      miscompares++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi,
               got);
    end
  endtask

  // Builds a packet, flips the top bit of byte bad when bad >= 0, reports the answer
  task automatic send_pkt(input logic [15:0] s, input int bad,
                          output int acc_at, output int rej_at);
    logic [7:0] p [14];
    logic [15:0] ck;
    p[0] = {5'b00011, APP[6:4]};
    p[1] = {APP[3:0], 4'hc};
    p[2] = {5'b11000, seq[10:8]};
    p[3] = seq[7:0];
    p[4] = 8'h00;
    p[5] = 8'h07;
    p[6] = 8'h11;
    p[7] = 8'hc0;
    p[8] = 8'h0c;
    p[9] = 8'h00;
    p[10] = s[15:8];
    p[11] = s[7:0];
    ck = 16'h0000;
    for (int i = 0; i < 12; i += 2) ck ^= {p[i], p[i+1]};
    p[12] = ck[15:8];
    p[13] = ck[7:0];
    if (bad >= 0) p[bad] ^= 8'h80;
    seq++;
    acc_at = 0;
    rej_at = 0;
    for (int i = 0; i < 14; i++) begin
      @(negedge clk);
      tc_byte = p[i];
      tc_valid = 1'b1;
      tc_sop = (i == 0);
    end
    @(negedge clk);
    tc_valid = 1'b0;
    tc_sop = 1'b0;
    for (int n = 1; n <= 4; n++) begin
      @(posedge clk);
      #1;
      if (acc === 1'b1) acc_at = n;
      if (rej === 1'b1) rej_at = n;
    end
  endtask

  task automatic pulse_start();
    @(negedge clk);
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
  endtask

  // Counts clocks while the scan timer runs
  task automatic run_len(output int n);
    int w;
    w = 0;
    n = 0;
    while (run !== 1'b1 && w < 20) begin
      @(posedge clk);
      #1;
      w++;
    end
    while (run === 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic wait_done();
    int w;
    w = 0;
    while (done !== 1'b1 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("setting", 32'h7622, setting);
    check("cycles", 32'h36220, cycles);
    check("min gap", 32'd10000, min_gap);
    check("eng", 32'h0, eng);
    $display("test reset done");
  endtask

  task automatic t_accept();
    logic [15:0] s [4] = '{16'h0005, 16'h4003, 16'hc002, 16'h8007};
    int e [4] = '{5, 48, 8192, 1792};
    int a, r;
    for (int i = 0; i < 4; i++) begin
      send_pkt(s[i], -1, a, r);
      check("accept cycle", 32'd1, a);
      check("setting", 32'(s[i]), setting);
      check("cycles", 32'(e[i]), cycles);
    end
    $display("test accept done");
  endtask

  task automatic t_refuse();
    int ix [8] = '{0, 1, 2, 5, 6, 12, 7, 8};
    int a, r;
    for (int i = 0; i < 8; i++) begin
      send_pkt(16'h0011, ix[i], a, r);
      check("no accept", 32'd0, a);
      check("reject", (i < 6) ? 32'd1 : 32'd0, r);
      check("kept", 32'h8007, setting);
    end
    // A fresh start while a matching packet is open cuts it short
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      tc_byte = {5'b00011, APP[6:4]};
      tc_valid = 1'b1;
      tc_sop = 1'b1;
    end
    @(negedge clk);
    tc_valid = 1'b0;
    tc_sop = 1'b0;
    @(posedge clk);
    #1;
    check("cut short", 32'd1, rej);
    $display("test refuse done");
  endtask

  task automatic t_scan_gap();
    int a, r, n;
    send_pkt(16'h0002, -1, a, r);
    fork
      run_len(n);
      begin
        pulse_start();
        repeat (20) @(negedge clk);
        send_pkt(16'h0001, -1, a, r);
      end
    join
    check_range("run clocks", 1115, 1117, n);
    wait_done();
    check_range("last gap", 3, 4, last_gap);
    check("min gap", 32'(last_gap), min_gap);
    check_range("avg", 1, 3, avg);
    fork
      run_len(n);
      pulse_start();
    join
    check_range("run clocks", 557, 559, n);
    wait_done();
    send_pkt(16'h0002, -1, a, r);
    check("avg clear", 32'd0, avg);
    check("min reload", 32'd10000, min_gap);
    $display("test scan gap done");
  endtask

  task automatic t_fail();
    int w;
    w = 0;
    stuck = 1'b1;
    pulse_start();
    while (err !== 1'b1 && w < 3000) begin
      @(posedge clk);
      #1;
      w++;
    end
    check("error event", 32'd1, err);
    @(posedge clk);
    #1;
    check("error pulse", 32'd0, err);
    check("eng", 32'd1, eng);
    check("run", 32'd0, run);
    pulse_start();
    repeat (3) @(posedge clk);
    #1;
    check("start refused", 32'd0, run);
    @(negedge clk);
    sw_restart = 1'b1;
    @(negedge clk);
    sw_restart = 1'b0;
    stuck = 1'b0;
    check("eng cleared", 32'd0, eng);
    check("setting", 32'h7622, setting);
    check("cycles", 32'h36220, cycles);
    $display("test fail done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    tc_byte = 8'h00;
    tc_valid = 1'b0;
    tc_sop = 1'b0;
    sw_restart = 1'b0;
    scan_start = 1'b0;
    stuck = 1'b0;
    seq = 11'h000;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_accept();
    t_refuse();
    t_scan_gap();
    t_fail();
    close_out();
  end
endmodule
